/* File: src/sram_port_pkg.sv */
// Purpose: constants shared by the asynchronous sram host port
// Assumes: 50 MHz core clock, 70 ns speed grade memory
// Notes:   times in ns as printed, cycle counts derived by rounding
package sram_port_pkg;

   localparam int CLK_PERIOD_NS = 20;

   // memory organisation
   localparam int ADDR_BITS     = 19;
   localparam int DATA_BITS     = 16;
   localparam int LANE_BITS     = 8;
   localparam int SYNC_STAGES   = 2;

   // least times, rounded up to whole cycles
   localparam int T_RC_NS       = 70;
   localparam int T_AA_NS       = 70;
   localparam int T_WC_NS       = 70;
   localparam int T_PWE_NS      = 50;
   localparam int T_SCE_NS      = 60;
   localparam int T_AW_NS       = 60;
   localparam int T_SD_NS       = 30;
   localparam int T_HZOE_NS     = 25;

   function automatic int cycles_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : cycles_up

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction : max2

   localparam int RD_CYC       = cycles_up(max2(T_RC_NS, T_AA_NS));
   localparam int WR_PULSE_CYC = cycles_up(max2(max2(T_PWE_NS, T_SCE_NS),
                                           max2(T_AW_NS, T_SD_NS)));
   localparam int WR_END_CYC   = max2(cycles_up(T_WC_NS) - WR_PULSE_CYC, 1);
   localparam int TURN_CYC     = cycles_up(T_HZOE_NS);
   // pins held long enough for valid data to cross the synchroniser
   localparam int RD_HOLD_CYC  = RD_CYC + SYNC_STAGES + 1;

   localparam int CNT_BITS     = 4;

   typedef enum logic [2:0] {
      st_idle,
      st_read,
      st_turn,
      st_write,
      st_wend
   } port_state_t;

endpackage : sram_port_pkg

/* File: src/pin_sync.sv */
// Purpose: two flip-flop synchroniser for the returning data pins
// Assumes: pins change only while the memory drives or floats them
// Notes:   first stage is read by the second stage alone
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync_out
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stage1_q <= '0;
         stage2_q <= '0;
      end
      else
      begin
         stage1_q <= pin_in;
         stage2_q <= stage1_q;
      end
   end

   assign pin_sync_out = stage2_q;

endmodule : pin_sync
`default_nettype wire

/* File: src/sram_host_port.sv */
// Purpose: host controller driving an asynchronous 16-bit sram
// Assumes: one request at a time, memory pins wired straight out
// Notes:   every pin comes from a flip-flop, no glitch on selects
//
// How it works
// - write spans select and strobe overlap
// - strobe held high through every read
// - never drive data while memory drives
// - address and selects change on the same edge
`timescale 1ns/10ps
`default_nettype none
module sram_host_port
   import sram_port_pkg::*;
#(
   parameter int ADDR_W = ADDR_BITS,
   parameter int DATA_W = DATA_BITS
) (
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic [1:0]        req_byte_en,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_rdata,
   output logic      [ADDR_W-1:0] mem_addr,
   output logic                   chip_select_low_active,
   output logic                   chip_select_high_active,
   output logic                   write_strobe_n,
   output logic                   output_drive_n,
   output logic                   upper_lane_select_n,
   output logic                   lower_lane_select_n,
   input  wire logic [DATA_W-1:0] mem_data_in,
   output logic      [DATA_W-1:0] mem_data_out,
   output logic                   mem_data_oe
);

   // the lane split below assumes exactly two byte lanes
   if (ADDR_W != ADDR_BITS || DATA_W != 2 * LANE_BITS)
   begin : g_bad_size
      $error("sram_host_port: unsupported address or data width");
   end

   localparam logic [CNT_BITS-1:0] RD_LOAD   = CNT_BITS'(RD_HOLD_CYC - 1);
   localparam logic [CNT_BITS-1:0] WR_LOAD   = CNT_BITS'(WR_PULSE_CYC - 1);
   localparam logic [CNT_BITS-1:0] WEND_LOAD = CNT_BITS'(WR_END_CYC - 1);
   localparam logic [CNT_BITS-1:0] TURN_LOAD = CNT_BITS'(TURN_CYC - 1);

   port_state_t         state_q;
   port_state_t         state_d;
   logic [CNT_BITS-1:0] cnt_q;
   logic [CNT_BITS-1:0] cnt_d;
   logic [ADDR_W-1:0]   addr_q;
   logic [DATA_W-1:0]   wdata_q;
   logic [1:0]          lanes_n_q;
   logic [1:0]          lanes_n_d;
   logic                cs_q;
   logic                cs_d;
   logic                we_n_q;
   logic                we_n_d;
   logic                oe_n_q;
   logic                oe_n_d;
   logic                doe_q;
   logic                doe_d;
   logic                ready_q;
   logic                rsp_valid_q;
   logic [DATA_W-1:0]   rdata_q;
   logic [DATA_W-1:0]   data_sync;

   pin_sync #(
      .WIDTH (DATA_W)
   ) u_data_sync (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .pin_in       (mem_data_in),
      .pin_sync_out (data_sync)
   );

   wire take      = req_valid && ready_q;
   wire cnt_done  = (cnt_q == '0);
   wire read_done = (state_q == st_read) && cnt_done;
   // no enabled lane would deselect the part; promote to a full word
   wire [1:0] req_lanes_n = (req_byte_en == 2'b00) ? 2'b00 : ~req_byte_en;
   // lanes not selected read back as zero
   wire [DATA_W-1:0] lane_mask = {{LANE_BITS{!lanes_n_q[1]}},
                                  {LANE_BITS{!lanes_n_q[0]}}};

   always_comb
   begin
      state_d   = state_q;
      cnt_d     = cnt_done ? cnt_q : cnt_q - 1'b1;
      cs_d      = cs_q;
      we_n_d    = we_n_q;
      oe_n_d    = oe_n_q;
      doe_d     = doe_q;
      lanes_n_d = lanes_n_q;
      case (state_q)
         st_idle:
         begin
            doe_d = 1'b0;
            if (take)
            begin
               // address and selects leave on the same edge
               cs_d      = 1'b1;
               lanes_n_d = req_lanes_n;
               if (req_write)
               begin
                  state_d = st_write;
                  cnt_d   = WR_LOAD;
                  we_n_d  = 1'b0;
                  oe_n_d  = 1'b1;
                  doe_d   = 1'b1;
               end
               else
               begin
                  state_d = st_read;
                  cnt_d   = RD_LOAD;
                  we_n_d  = 1'b1;
                  oe_n_d  = 1'b0;
               end
            end
         end
         st_read:
         begin
            if (cnt_done)
            begin
               state_d   = st_turn;
               cnt_d     = TURN_LOAD;
               cs_d      = 1'b0;
               oe_n_d    = 1'b1;
               lanes_n_d = 2'b11;
            end
         end
         st_turn:
         begin
            // memory may still drive the bus for its float time
            if (cnt_done)
            begin
               state_d = st_idle;
            end
         end
         st_write:
         begin
            if (cnt_done)
            begin
               // strobe and selects rise together, data still held
               state_d   = st_wend;
               cnt_d     = WEND_LOAD;
               we_n_d    = 1'b1;
               cs_d      = 1'b0;
               lanes_n_d = 2'b11;
            end
         end
         st_wend:
         begin
            if (cnt_done)
            begin
               state_d = st_idle;
               doe_d   = 1'b0;
            end
         end
         default:
         begin
            state_d = st_idle;
            cs_d    = 1'b0;
            we_n_d  = 1'b1;
            oe_n_d  = 1'b1;
            doe_d   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q   <= st_idle;
         cnt_q     <= '0;
         cs_q      <= 1'b0;
         we_n_q    <= 1'b1;
         oe_n_q    <= 1'b1;
         doe_q     <= 1'b0;
         lanes_n_q <= 2'b11;
      end
      else
      begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         cs_q      <= cs_d;
         we_n_q    <= we_n_d;
         oe_n_q    <= oe_n_d;
         doe_q     <= doe_d;
         lanes_n_q <= lanes_n_d;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr_q      <= '0;
         wdata_q     <= '0;
         ready_q     <= 1'b0;
         rsp_valid_q <= 1'b0;
         rdata_q     <= '0;
      end
      else
      begin
         if (take)
         begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
         end
         ready_q     <= (state_d == st_idle);
         rsp_valid_q <= read_done;
         if (read_done)
         begin
            rdata_q <= data_sync & lane_mask;
         end
      end
   end

   assign req_ready               = ready_q;
   assign rsp_valid               = rsp_valid_q;
   assign rsp_rdata               = rdata_q;
   assign mem_addr                = addr_q;
   assign chip_select_low_active  = !cs_q;
   assign chip_select_high_active = cs_q;
   assign write_strobe_n          = we_n_q;
   assign output_drive_n          = oe_n_q;
   assign upper_lane_select_n     = lanes_n_q[1];
   assign lower_lane_select_n     = lanes_n_q[0];
   assign mem_data_out            = wdata_q;
   assign mem_data_oe             = doe_q;

   sequence s_read_start;
      $fell(chip_select_low_active) && write_strobe_n;
   endsequence

   sequence s_write_start;
      $fell(write_strobe_n) && !chip_select_low_active;
   endsequence

   property p_no_contention;
      @(posedge core_clk) disable iff (!reset_n)
      mem_data_oe |-> output_drive_n;
   endproperty
   a_no_contention: assert property (p_no_contention)
      else $error("data driven while memory output enabled");

   property p_turnaround;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(output_drive_n) |-> !mem_data_oe [*2];
   endproperty
   a_turnaround: assert property (p_turnaround)
      else $error("bus driven too soon after read");

   property p_read_strobe_high;
      @(posedge core_clk) disable iff (!reset_n)
      (!chip_select_low_active && !output_drive_n) |-> write_strobe_n;
   endproperty
   a_read_strobe_high: assert property (p_read_strobe_high)
      else $error("write strobe low during read");

   property p_read_len;
      @(posedge core_clk) disable iff (!reset_n)
      s_read_start |-> !chip_select_low_active [*7] ##1
                       chip_select_low_active;
   endproperty
   a_read_len: assert property (p_read_len)
      else $error("read access length wrong");

   property p_read_rsp;
      @(posedge core_clk) disable iff (!reset_n)
      s_read_start |-> ##7 rsp_valid;
   endproperty
   a_read_rsp: assert property (p_read_rsp)
      else $error("read answer not on time");

   property p_write_pulse;
      @(posedge core_clk) disable iff (!reset_n)
      s_write_start |-> !write_strobe_n [*3] ##1
                        (write_strobe_n && chip_select_low_active);
   endproperty
   a_write_pulse: assert property (p_write_pulse)
      else $error("write pulse width wrong");

   property p_write_end_data;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(write_strobe_n) |-> mem_data_oe && $stable(mem_data_out);
   endproperty
   a_write_end_data: assert property (p_write_end_data)
      else $error("write data not held at write end");

   property p_selects_together;
      @(posedge core_clk) disable iff (!reset_n)
      chip_select_high_active == !chip_select_low_active;
   endproperty
   a_selects_together: assert property (p_selects_together)
      else $error("chip selects out of step");

   property p_addr_stable;
      @(posedge core_clk) disable iff (!reset_n)
      (!chip_select_low_active && $past(!chip_select_low_active))
         |-> $stable(mem_addr);
   endproperty
   a_addr_stable: assert property (p_addr_stable)
      else $error("address moved during access");

   property p_lane_active;
      @(posedge core_clk) disable iff (!reset_n)
      !chip_select_low_active |->
         !(upper_lane_select_n && lower_lane_select_n);
   endproperty
   a_lane_active: assert property (p_lane_active)
      else $error("selected with no byte lane");

endmodule : sram_host_port
`default_nettype wire

/* File: tb/sram_lane_model.sv */
// Purpose: behavioural model of the 512K x 16 sram at the host pins
// Assumes: pins come straight from the host flip-flops
// Notes:   undriven lanes show a pattern that flips every clock
`timescale 1ns/10ps
`default_nettype none
module sram_lane_model
   import sram_port_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic [ADDR_BITS-1:0] mem_addr,
   input  wire logic                 chip_select_low_active,
   input  wire logic                 chip_select_high_active,
   input  wire logic                 write_strobe_n,
   input  wire logic                 output_drive_n,
   input  wire logic                 upper_lane_select_n,
   input  wire logic                 lower_lane_select_n,
   input  wire logic                 host_oe,
   input  wire logic [DATA_BITS-1:0] bus_in,
   output logic      [DATA_BITS-1:0] bus_out,
   output logic      [7:0]           viol
);
   // two-state array: unwritten words read as zero, no sparse map needed
   bit   [DATA_BITS-1:0] mem [0:(2**ADDR_BITS)-1];
   logic [7:0]           bus_viol = 8'h00;
   logic [7:0]           addr_viol = 8'h00;
   logic [DATA_BITS-1:0] float_q = 16'h5a5a;
   logic [DATA_BITS-1:0] word;
   logic [DATA_BITS-1:0] tmp;
   logic [DATA_BITS-1:0] data_d;
   logic [ADDR_BITS-1:0] addr_d;
   logic [1:0]           lanes_d;
   logic                 sel;
   logic                 sel_d;
   logic                 wr_act;
   logic                 rd_act;
   logic [1:0]           drv;

   assign sel = !chip_select_low_active && chip_select_high_active
                && !(upper_lane_select_n && lower_lane_select_n);
   assign wr_act = sel && !write_strobe_n;
   assign rd_act = sel && write_strobe_n && !output_drive_n;
   assign drv = rd_act ? {!upper_lane_select_n, !lower_lane_select_n}
                       : 2'b00;
   assign word = mem[mem_addr];
   assign bus_out = {drv[1] ? word[15:8] : float_q[15:8],
                     drv[0] ? word[7:0] : float_q[7:0]};
   // delayed copies: pins all move on one edge, the write end sees old
   assign #1 data_d = bus_in;
   assign #1 addr_d = mem_addr;
   assign #1 sel_d = sel;
   assign #1 lanes_d = {!upper_lane_select_n, !lower_lane_select_n};
   // one counter per checker so two hits in one step both count
   assign viol = bus_viol + addr_viol;

   always @(posedge core_clk) float_q <= ~float_q;

   always @(negedge wr_act)
   begin
      if (!$isunknown(addr_d) && !$isunknown(lanes_d))
      begin
         tmp = mem[addr_d];
         if (lanes_d[0])
            tmp[7:0] = data_d[7:0];
         if (lanes_d[1])
            tmp[15:8] = data_d[15:8];
         mem[addr_d] = tmp;
      end
   end

   always @(negedge core_clk)
      if (host_oe === 1'b1 && drv !== 2'b00)
         bus_viol <= bus_viol + 8'h01;
   always @(mem_addr)
      if (sel_d === 1'b1)
         addr_viol <= addr_viol + 8'h01;
endmodule : sram_lane_model
`default_nettype wire

/* File: tb/sram_host_port_tb.sv */
// Purpose: self-checking bench for the sram host port
// Assumes: one request at a time, model on the memory pins
// Notes:   disabled lanes read back as zero, unless no lane is enabled
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   $display("wrong value %s expected %h seen %h", n, e, g); \
   err_count++; end end
module sram_host_port_tb
   import sram_port_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic [18:0] req_addr = 19'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0]  req_byte_en = 2'b00;
   logic        req_ready, rsp_valid, mem_data_oe;
   logic [15:0] rsp_rdata, mem_data_out, sram_bus, mem_bus, q;
   logic [18:0] mem_addr;
   logic        chip_select_low_active, chip_select_high_active;
   logic        write_strobe_n, output_drive_n;
   logic        upper_lane_select_n, lower_lane_select_n;
   logic [7:0]  viol;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   assign mem_bus = mem_data_oe ? mem_data_out : sram_bus;
   always #10 core_clk = ~core_clk;

   sram_host_port dut (.core_clk, .reset_n, .req_valid, .req_write,
      .req_addr, .req_wdata, .req_byte_en, .req_ready, .rsp_valid,
      .rsp_rdata, .mem_addr, .chip_select_low_active,
      .chip_select_high_active, .write_strobe_n, .output_drive_n,
      .upper_lane_select_n, .lower_lane_select_n,
      .mem_data_in(mem_bus), .mem_data_out, .mem_data_oe);
   sram_lane_model model (.core_clk, .mem_addr, .chip_select_low_active,
      .chip_select_high_active, .write_strobe_n, .output_drive_n,
      .upper_lane_select_n, .lower_lane_select_n, .host_oe(mem_data_oe),
      .bus_in(mem_bus), .bus_out(sram_bus), .viol);

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // one access; pins checked in the first cycle after the take
   task automatic access(input logic wr, input logic [18:0] a,
      input logic [15:0] d, input logic [1:0] be);
      int n;
      logic [1:0] ln;
      ln = ~((be == 2'b00) ? 2'b11 : be);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      req_byte_en <= be;
      do @(posedge core_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      @(negedge core_clk);
      `CHK("addr", a, mem_addr)
      `CHK("lanes", ln, {upper_lane_select_n, lower_lane_select_n})
      `CHK("cs low", 1'b0, chip_select_low_active)
      `CHK("cs high", 1'b1, chip_select_high_active)
      `CHK("we_n", !wr, write_strobe_n)
      `CHK("oe_n", wr, output_drive_n)
      `CHK("busy", 1'b0, req_ready)
      `CHK("data_oe", wr, mem_data_oe)
      if (wr)
         `CHK("wdata", d, mem_data_out)
      n = 1;
      while (!wr && rsp_valid !== 1'b1 && n < 20)
      begin
         @(negedge core_clk);
         n++;
      end
      q = rsp_rdata;
      if (!wr)
         `CHK("latency", 8, n)
   endtask : access

   task automatic rd_chk(input logic [18:0] a, input logic [1:0] be,
      input logic [15:0] e);
      access(1'b0, a, 16'h0000, be);
      `CHK("rdata", e, q)
      @(negedge core_clk);
      `CHK("rsp pulse", 1'b0, rsp_valid)
   endtask : rd_chk

   task automatic t_reset();
      `CHK("idle cs", 1'b1, chip_select_low_active)
      `CHK("idle upper", 1'b1, upper_lane_select_n)
      `CHK("idle lower", 1'b1, lower_lane_select_n)
      `CHK("idle we oe", 2'b11, {write_strobe_n, output_drive_n})
      `CHK("idle oe", 1'b0, mem_data_oe)
   endtask : t_reset

   task automatic t_full();
      access(1'b1, 19'h7ffff, 16'hbeef, 2'b11);
      access(1'b1, 19'h00000, 16'h1234, 2'b11);
      rd_chk(19'h7ffff, 2'b11, 16'hbeef);
      rd_chk(19'h00000, 2'b11, 16'h1234);
   endtask : t_full

   task automatic t_lanes();
      access(1'b1, 19'h00155, 16'haaaa, 2'b11);
      access(1'b1, 19'h00155, 16'h1155, 2'b01);
      rd_chk(19'h00155, 2'b11, 16'haa55);
      access(1'b1, 19'h00155, 16'h66bb, 2'b10);
      rd_chk(19'h00155, 2'b00, 16'h6655);
      rd_chk(19'h00155, 2'b01, 16'h0055);
      rd_chk(19'h00155, 2'b10, 16'h6600);
   endtask : t_lanes

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_count++;
         final_report();
      end
   end

   initial
   begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      t_reset();
      t_full();
      t_lanes();
      repeat (12) @(negedge core_clk);
      `CHK("pin faults", 8'h00, viol)
      final_report();
   end
endmodule : sram_host_port_tb
`default_nettype wire
